// >>> codec_power_ctrl.sv
// Power sequencing, parameter RAM and general control registers of the image codec.
`timescale 1ns/10ps
`include "codec_consts.svh"
// Contract
// - While sleeping, all internal state except the power sequencer and its lock count is frozen by withholding the clock enable.
// - While sleeping, pin direction and outputs other than power status hold their last values; host_rvalid and load_valid are held low.
// - Waking needs no reset; all registers and parameters are kept.
// - Each rising edge of the sleep pin starts a 5000-cycle lock, still asleep.
// - 1024-byte parameter RAM streamed out to the internal blocks only on load.
// - Sync-reset bit holds the sync generator at zero until cleared.
// - Writing load 1 copies all parameters with busy set; 0 does nothing.
// - Level field reports occupancy in quarters, valid while no end-of-image.
// - Full/empty bit is the inverted code-busy pin, driven in slave mode.
// - Code-bus role bit: 0 slave, 1 master, resets to 1.
// - In master mode the speed bit picks one or two cycles per byte.
// - In 16-bit slave mode the order bit picks the first byte lanes.
// - In slave mode the width bit picks 8-bit or 16-bit code bus.
// - Block code limit is twice the block-limit register value.
// - Segment enable bits act only in compression.
module codec_power_ctrl
   import codec_pkg::*;
#(
   parameter int LOCK_CYCLES = `LOCK_CYCLES,
   parameter int LEVEL_DEPTH = `LEVEL_DEPTH,
   parameter int LEVEL_W = 7
)
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rstn,
   // Power pin, active low.
   input wire logic sleep_n,
   // Host access port.
   input wire logic host_rd,
   input wire logic host_wr,
   input wire logic [`ADDR_W-1:0] host_addr,
   input wire logic [7:0] host_wdata,
   output logic [7:0] host_rdata,
   output logic host_rvalid,
   // Code buffer state from the datapath.
   input wire logic [LEVEL_W-1:0] code_fill,
   input wire logic code_buf_full,
   input wire logic code_buf_empty,
   input wire logic end_of_image,
   // Code busy pin, active low, driven only in slave mode.
   output logic code_busy_n_o,
   output logic code_busy_n_oe,
   // Power status and clock enable for the rest of the core.
   output logic core_run,
   output logic asleep,
   // Parameter load stream to the internal blocks.
   output logic load_valid,
   output logic [`ADDR_W-1:0] load_addr,
   output logic [7:0] load_data,
   output logic load_busy,
   // Working configuration.
   output logic sync_generator_reset,
   output logic code_bus_role,
   output logic code_transfer_speed,
   output logic code_byte_order,
   output logic code_bus_wide,
   output logic [7:0] op_select,
   output logic [8:0] block_bit_budget,
   output logic [4:0] segment_enable
);
   if (LOCK_CYCLES < 1 || LOCK_CYCLES > 8192 || LEVEL_DEPTH < 4 || (1 << LEVEL_W) <= LEVEL_DEPTH)
   begin : g_chk
      $error("codec_power_ctrl parameters out of range");
   end

   localparam logic [12:0] LOCK_LAST = 13'(LOCK_CYCLES - 1);
   localparam logic [LEVEL_W-1:0] Q1 = LEVEL_W'(LEVEL_DEPTH / 4);
   localparam logic [LEVEL_W-1:0] Q2 = LEVEL_W'(LEVEL_DEPTH / 2);
   localparam logic [LEVEL_W-1:0] Q3 = LEVEL_W'((LEVEL_DEPTH * 3) / 4);
   localparam logic [`ADDR_W-1:0] WALK_LAST = `ADDR_W'(`RAM_BYTES - 1);

   power_state_t pwr_r;
   power_state_t pwr_nxt;
   load_state_t ld_r;
   load_state_t ld_nxt;
   logic sleep_s;
   logic sleep_d_r;
   logic [12:0] lock_r;
   logic sync_rst_r;
   logic [7:0] cfg_r;
   logic [7:0] opsel_r;
   logic [7:0] limit_r;
   logic [7:0] segen_r;
   logic [7:0] cfg_work_r;
   logic [7:0] opsel_work_r;
   logic [7:0] limit_work_r;
   logic [7:0] segen_work_r;
   logic [1:0] level_r;
   logic fe_r;
   logic [`ADDR_W-1:0] walk_r;
   logic walk_v_r;
   logic [`ADDR_W-1:0] walk_a_r;
   logic [7:0] ram_q;
   logic [7:0] reg_rd_r;
   logic rd_reg_r;
   logic rvalid_r;
   logic [`ADDR_W-1:0] rd_a_r;

   // Synchronised sleep pin and its rising edge.
   pin_sync u_sleep_sync (
      .mclk(mclk),
      .rstn(rstn),
      .din(sleep_n),
      .dout(sleep_s)
   );

   wire wake_edge = sleep_s & ~sleep_d_r;
   wire run = (pwr_r == PWR_RUN);
   wire frozen = ~run;
   wire acc_ok = run & (ld_r == LD_IDLE);
   wire wr_ok = host_wr & acc_ok;
   wire rd_ok = host_rd & acc_ok;
   wire hit_load = (host_addr == `OFS_LOAD);
   wire hit_reg = (host_addr <= `OFS_SEGEN);
   wire wr_load = wr_ok & hit_load;
   wire start_load = wr_load & host_wdata[`BIT_LOAD];
   wire ram_we = wr_ok & ~hit_reg;
   wire [`ADDR_W-1:0] ram_addr = (ld_r == LD_WALK) ? walk_r :
                                 (wr_ok | rd_ok) ? host_addr : rd_a_r;
   wire slave = ~cfg_work_r[`BIT_ROLE];
   wire compress = opsel_work_r[`BIT_COMPRESS];
   wire fe_now = code_buf_full | code_buf_empty;
   wire [1:0] level_now = (code_fill >= Q3) ? 2'b11 :
                          (code_fill >= Q2) ? 2'b10 :
                          (code_fill >= Q1) ? 2'b01 : 2'b00;
   wire [7:0] stat_val = {(ld_r != LD_IDLE), 4'h0, fe_r, level_r};
   wire [7:0] reg_val = (host_addr == `OFS_LOAD) ? {7'h00, sync_rst_r} :
                        (host_addr == `OFS_BUFSTAT) ? stat_val :
                        (host_addr == `OFS_PORTCFG) ? cfg_r :
                        (host_addr == `OFS_OPSEL) ? opsel_r :
                        (host_addr == `OFS_LIMIT) ? limit_r :
                        (host_addr == `OFS_SEGEN) ? segen_r : `RST_ZERO;

   param_ram #(
      .DEPTH(`RAM_BYTES),
      .AW(`ADDR_W)
   ) u_ram (
      .mclk(mclk),
      .we(ram_we),
      .addr(ram_addr),
      .wdata(host_wdata),
      .rdata(ram_q)
   );

   // Power sequencing: a rising pin edge runs the lock count before waking.
   always_comb
   begin
      pwr_nxt = pwr_r;
      unique case (pwr_r)
         PWR_RUN:
            if (!sleep_s)
               pwr_nxt = PWR_SLEEP;
         PWR_SLEEP:
            if (wake_edge)
               pwr_nxt = PWR_LOCK;
         PWR_LOCK:
            if (!sleep_s)
               pwr_nxt = PWR_SLEEP;
            else if (lock_r == LOCK_LAST)
               pwr_nxt = PWR_RUN;
         default:
            pwr_nxt = PWR_SLEEP;
      endcase
   end
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         pwr_r <= PWR_RUN;
         sleep_d_r <= 1'b1;
         lock_r <= 13'h0000;
      end
      else
      begin
         pwr_r <= pwr_nxt;
         sleep_d_r <= sleep_s;
         lock_r <= (pwr_r == PWR_LOCK) ? lock_r + 13'h0001 : 13'h0000;
      end
   end

   // Load sequencer walks every RAM byte out to the internal blocks.
   always_comb
   begin
      ld_nxt = ld_r;
      unique case (ld_r)
         LD_IDLE:
            if (start_load)
               ld_nxt = LD_WALK;
         LD_WALK:
            if (walk_r == WALK_LAST)
               ld_nxt = LD_DRAIN;
         LD_DRAIN:
            ld_nxt = LD_IDLE;
         default:
            ld_nxt = LD_IDLE;
      endcase
   end
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         ld_r <= LD_IDLE;
         walk_r <= 10'h000;
         walk_v_r <= 1'b0;
         walk_a_r <= 10'h000;
      end
      else if (!frozen)
      begin
         ld_r <= ld_nxt;
         walk_r <= (ld_r == LD_WALK) ? walk_r + 10'h001 : 10'h000;
         walk_v_r <= (ld_r == LD_WALK);
         walk_a_r <= walk_r;
      end
   end

   // Host-visible control registers, written only while awake and not loading.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         sync_rst_r <= 1'b0;
         cfg_r <= `RST_PORTCFG;
         opsel_r <= `RST_OPSEL;
         limit_r <= `RST_ZERO;
         segen_r <= `RST_ZERO;
      end
      else if (wr_ok)
      begin
         if (hit_load)
            sync_rst_r <= host_wdata[`BIT_SYNC_RESET];
         if (host_addr == `OFS_PORTCFG)
            cfg_r <= host_wdata & 8'hc5;
         if (host_addr == `OFS_OPSEL)
            opsel_r <= host_wdata & 8'hf6;
         if (host_addr == `OFS_LIMIT)
            limit_r <= host_wdata;
         if (host_addr == `OFS_SEGEN)
            segen_r <= host_wdata & 8'hf8;
      end
   end

   // Working copies change only when a load completes.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         cfg_work_r <= `RST_PORTCFG;
         opsel_work_r <= `RST_OPSEL;
         limit_work_r <= `RST_ZERO;
         segen_work_r <= `RST_ZERO;
      end
      else if (!frozen && ld_r == LD_DRAIN)
      begin
         cfg_work_r <= cfg_r;
         opsel_work_r <= opsel_r;
         limit_work_r <= limit_r;
         segen_work_r <= segen_r;
      end
   end

   // Code buffer status, level held while end-of-image is asserted.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         level_r <= 2'b00;
         fe_r <= 1'b0;
      end
      else if (!frozen)
      begin
         if (!end_of_image)
            level_r <= level_now;
         fe_r <= fe_now;
      end
   end

   // Host read path: register values or RAM bytes one cycle after the strobe.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         reg_rd_r <= `RST_ZERO;
         rd_reg_r <= 1'b0;
         rvalid_r <= 1'b0;
         rd_a_r <= 10'h000;
      end
      else if (!frozen)
      begin
         rvalid_r <= rd_ok;
         if (rd_ok)
         begin
            reg_rd_r <= reg_val;
            rd_reg_r <= hit_reg;
            rd_a_r <= host_addr;
         end
      end
   end

   assign host_rdata = rd_reg_r ? reg_rd_r : ram_q;
   assign host_rvalid = rvalid_r & run;
   assign core_run = run;
   assign asleep = frozen;
   assign load_valid = walk_v_r & run;
   assign load_addr = walk_a_r;
   assign load_data = ram_q;
   assign load_busy = (ld_r != LD_IDLE);
   assign sync_generator_reset = sync_rst_r;
   assign code_busy_n_o = ~fe_r;
   assign code_busy_n_oe = slave;
   assign code_bus_role = cfg_work_r[`BIT_ROLE];
   assign code_transfer_speed = ~slave & cfg_work_r[`BIT_SPEED];
   assign code_bus_wide = slave & cfg_work_r[`BIT_WIDE];
   assign code_byte_order = code_bus_wide & cfg_work_r[`BIT_ORDER];
   assign op_select = opsel_work_r;
   assign block_bit_budget = {limit_work_r, 1'b0};
   assign segment_enable = compress ? segen_work_r[7:3] : 5'h00;
endmodule

// >>> codec_consts.svh
// Register offsets, field positions, reset values and timing counts of the codec control bank.
`ifndef CODEC_CONSTS_SVH
`define CODEC_CONSTS_SVH

`define ADDR_W 10
`define RAM_BYTES 1024
`define OFS_LOAD 10'h000
`define OFS_BUFSTAT 10'h001
`define OFS_PORTCFG 10'h002
`define OFS_OPSEL 10'h003
`define OFS_RSVD 10'h004
`define OFS_LIMIT 10'h005
`define OFS_SEGEN 10'h006
`define BIT_SYNC_RESET 0
`define BIT_LOAD 7
`define BIT_BUSY 7
`define BIT_CODE_BUSY 2
`define BIT_ROLE 0
`define BIT_SPEED 2
`define BIT_ORDER 6
`define BIT_WIDE 7
`define BIT_COMPRESS 7
`define RST_PORTCFG 8'h01
`define RST_OPSEL 8'h80
`define RST_ZERO 8'h00
`define LOCK_CYCLES 5000
`define LEVEL_DEPTH 64

`endif

// >>> codec_pkg.sv
// State types shared by the codec control bank.
package codec_pkg;
   typedef enum logic [1:0] {
      PWR_RUN = 2'b00,
      PWR_SLEEP = 2'b01,
      PWR_LOCK = 2'b10
   } power_state_t;
   typedef enum logic [1:0] {
      LD_IDLE = 2'b00,
      LD_WALK = 2'b01,
      LD_DRAIN = 2'b10
   } load_state_t;
endpackage

// >>> pin_sync.sv
// Two-stage synchroniser for an asynchronous level input.
`timescale 1ns/10ps
module pin_sync
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rstn,
   // Level in and out.
   input wire logic din,
   output logic dout
);
   logic meta_r;

   // The output resets high so an idle active-low pin reads inactive.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta_r <= 1'b1;
         dout <= 1'b1;
      end
      else
      begin
         meta_r <= din;
         dout <= meta_r;
      end
   end
endmodule

// >>> param_ram.sv
// Single-port byte RAM with a registered read port.
`timescale 1ns/10ps
module param_ram
#(
   parameter int DEPTH = 1024,
   parameter int AW = 10
)
(
   // Clock.
   input wire logic mclk,
   // Access port.
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] mem [DEPTH];

   if (DEPTH > (1 << AW))
   begin : g_chk
      $error("param_ram depth exceeds address range");
   end

   always_ff @(posedge mclk)
   begin
      if (we)
      begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule

// >>> codec_power_ctrl_assertions.sv
// Concurrent checks on the ports of the codec control bank.
`timescale 1ns/10ps
`include "codec_consts.svh"
module codec_power_ctrl_chk
(
   // Watched ports.
   input wire logic mclk,
   input wire logic rstn,
   input wire logic host_rd,
   input wire logic host_wr,
   input wire logic [`ADDR_W-1:0] host_addr,
   input wire logic [7:0] host_wdata,
   input wire logic host_rvalid,
   input wire logic core_run,
   input wire logic asleep,
   input wire logic load_busy,
   input wire logic load_valid,
   input wire logic [`ADDR_W-1:0] load_addr,
   input wire logic code_buf_full,
   input wire logic code_buf_empty,
   input wire logic code_busy_n_o,
   input wire logic code_busy_n_oe,
   input wire logic code_bus_role,
   input wire logic [7:0] op_select,
   input wire logic [8:0] block_bit_budget,
   input wire logic [4:0] segment_enable
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   logic [7:0] lim_r;
   wire take = core_run && !load_busy;
   always_ff @(posedge mclk or negedge rstn)
      if (!rstn)
         lim_r <= 8'h00;
      else if (take && host_wr && host_addr == `OFS_LIMIT)
         lim_r <= host_wdata;
   a_read_answer: assert property (host_rd && take |=> host_rvalid)
      else $error("read not answered");
   a_asleep_flag: assert property (asleep == !core_run)
      else $error("asleep flag wrong");
   a_frozen_outputs: assert property (!core_run |=> $stable(op_select) &&
      $stable(block_bit_budget) && $stable(load_busy)) else $error("output moved asleep");
   a_load_start: assert property (host_wr && take && host_addr == `OFS_LOAD &&
      host_wdata[`BIT_LOAD] |=> load_busy) else $error("load did not start");
   a_load_stream: assert property ($rose(load_busy) |-> ##1 (load_valid &&
      load_addr == 10'h000)) else $error("load stream start wrong");
   a_busy_pin: assert property ($past(rstn) && $past(core_run) |->
      code_busy_n_o == !($past(code_buf_full) || $past(code_buf_empty)))
      else $error("busy pin wrong");
   a_pin_enable: assert property (code_busy_n_oe == !code_bus_role)
      else $error("busy pin enable wrong");
   a_budget_twice: assert property ($fell(load_busy) |-> block_bit_budget == {lim_r, 1'b0})
      else $error("block budget wrong");
   a_seg_decomp: assert property (!op_select[`BIT_COMPRESS] |-> segment_enable == 5'h00)
      else $error("segments on in decompression");
endmodule
bind codec_power_ctrl codec_power_ctrl_chk i_chk (.mclk, .rstn, .host_rd, .host_wr,
   .host_addr, .host_wdata, .host_rvalid, .core_run, .asleep, .load_busy, .load_valid,
   .load_addr, .code_buf_full, .code_buf_empty, .code_busy_n_o, .code_busy_n_oe,
   .code_bus_role, .op_select, .block_bit_budget, .segment_enable);

// >>> host_model.sv
// Host controller model driving the register port and the sleep pin.
`timescale 1ns/10ps
module host_model
(
   // Clock and load status.
   input wire logic mclk,
   input wire logic load_busy,
   // Host strobes and sleep pin.
   output logic host_rd,
   output logic host_wr,
   output logic [9:0] host_addr,
   output logic [7:0] host_wdata,
   output logic sleep_n
);
   initial
   begin
      host_rd = 1'b0;
      host_wr = 1'b0;
      host_addr = 10'h000;
      host_wdata = 8'h00;
      sleep_n = 1'b1;
   end
   task automatic access(input logic wr, input logic [9:0] a, input logic [7:0] d);
      int n;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (load_busy !== 1'b0 && n < 2000);
      host_wr <= wr;
      host_rd <= !wr;
      host_addr <= a;
      host_wdata <= d;
      @(posedge mclk);
      host_wr <= 1'b0;
      host_rd <= 1'b0;
   endtask
   task automatic nap(input int n);
      @(posedge mclk);
      sleep_n <= 1'b0;
      repeat (n) @(posedge mclk);
      sleep_n <= 1'b1;
   endtask
endmodule

// >>> codec_power_ctrl_tb_top.sv
// Self-checking testbench of the codec control bank.
`timescale 1ns/10ps
`include "codec_consts.svh"
module codec_power_ctrl_tb_top;
   localparam int LOCK = 20;
   logic mclk, rstn, end_of_image, code_buf_full, code_buf_empty, host_rd, host_wr, sleep_n;
   logic host_rvalid, code_busy_n_o, code_busy_n_oe, core_run, asleep, load_valid, load_busy;
   logic sync_generator_reset, code_bus_role, code_transfer_speed, code_byte_order, code_bus_wide;
   logic [9:0] host_addr, load_addr;
   logic [7:0] host_wdata, host_rdata, load_data, op_select, d, lim, seg, prev;
   logic [6:0] code_fill;
   logic [8:0] block_bit_budget;
   logic [4:0] segment_enable;
   logic [7:0] exp_q[$], msk_q[$];
   logic [7:0] ram_exp[2];
   logic [7:0] modes[6] = '{8'hc4, 8'h84, 8'ha4, 8'ha6, 8'hb0, 8'h00};
   logic [9:0] ofs[4] = '{10'h002, 10'h003, 10'h005, 10'h006};
   logic [7:0] msk[4] = '{8'hc5, 8'hf6, 8'hff, 8'hf8};
   logic [7:0] pc[3] = '{8'h05, 8'hc0, 8'h40};
   logic [3:0] pexp[3] = '{4'b1100, 4'b0011, 4'b0000};
   logic [6:0] fills[8] = '{7'd0, 7'd15, 7'd16, 7'd31, 7'd32, 7'd47, 7'd48, 7'd63};
   int err_total, checks, seed, n, cnt;
   codec_power_ctrl #(.LOCK_CYCLES(LOCK)) i_codec_power_ctrl (.mclk, .rstn, .sleep_n, .host_rd,
      .host_wr, .host_addr, .host_wdata, .host_rdata, .host_rvalid, .code_fill, .code_buf_full,
      .code_buf_empty, .end_of_image, .code_busy_n_o, .code_busy_n_oe, .core_run, .asleep,
      .load_valid, .load_addr, .load_data, .load_busy, .sync_generator_reset, .code_bus_role,
      .code_transfer_speed, .code_byte_order, .code_bus_wide, .op_select, .block_bit_budget,
      .segment_enable);
   host_model i_host_model (.mclk, .load_busy, .host_rd, .host_wr, .host_addr, .host_wdata,
      .sleep_n);
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] v);
      i_host_model.access(1'b1, a, v);
   endtask
   task automatic rd(input logic [9:0] a, input logic [7:0] e, input logic [7:0] m);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      i_host_model.access(1'b0, a, 8'h00);
   endtask
   task automatic do_load;
      wr(`OFS_LOAD, 8'h80);
      n = 0;
      cnt = 0;
      while (load_busy !== 1'b1 && n < 5)
      begin
         @(posedge mclk);
         n++;
      end
      while (load_busy === 1'b1 && n < 1200)
      begin
         @(posedge mclk);
         if (load_valid === 1'b1)
         begin
            check("load addr", 16'(cnt), 16'(load_addr));
            if (load_addr == 10'h007 || load_addr == 10'h3ff)
               check("load byte", 16'(ram_exp[load_addr[9]]), 16'(load_data));
            cnt++;
         end
         n++;
      end
      check("load bytes", 16'd1024, cnt[15:0]);
   endtask
   task automatic wait_run;
      n = 0;
      while (core_run !== 1'b1 && n < 200)
      begin
         @(posedge mclk);
         n++;
      end
   endtask
   task automatic wrap_up;
      if (exp_q.size() != 0)
         check("pending reads", 16'h0, 16'(exp_q.size()));
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge mclk)
      if (host_rvalid === 1'b1)
      begin
         if (exp_q.size() == 0)
            check("unexpected read", 16'h0, 16'h1);
         else
            check("read data", {8'h00, exp_q.pop_front()}, {8'h00, host_rdata & msk_q.pop_front()});
      end
   initial
   begin
      repeat (30000) @(posedge mclk);
      check("watchdog", 16'h0, 16'h1);
      wrap_up();
   end
   initial
   begin
      seed = 54682;
      rstn = 1'b0;
      end_of_image = 1'b0;
      code_buf_full = 1'b0;
      code_buf_empty = 1'b0;
      code_fill = 7'h00;
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      check("role", 16'h1, 16'(code_bus_role));
      i_host_model.nap(8);
      wait_run();
      check("first lock", 16'h1, 16'(n >= LOCK && n <= LOCK + 6));
      rd(`OFS_PORTCFG, `RST_PORTCFG, 8'hff);
      rd(`OFS_OPSEL, `RST_OPSEL, 8'hff);
      $display("test reset values done");
      for (int i = 0; i < 4; i++)
      begin
         d = 8'($random(seed));
         wr(ofs[i], d);
         rd(ofs[i], d & msk[i], msk[i]);
      end
      wr(`OFS_RSVD, 8'h5a);
      rd(`OFS_RSVD, 8'h00, 8'hff);
      for (int i = 0; i < 2; i++)
      begin
         d = 8'($random(seed));
         ram_exp[i] = d;
         wr(i ? 10'h3ff : 10'h007, d);
         rd(i ? 10'h3ff : 10'h007, d, 8'hff);
      end
      $display("test register access done");
      wr(`OFS_LOAD, 8'h01);
      @(posedge mclk);
      check("load ignored", 16'h0, 16'(load_busy));
      check("sync reset set", 16'h1, 16'(sync_generator_reset));
      rd(`OFS_LOAD, 8'h01, 8'hff);
      wr(`OFS_LOAD, 8'h00);
      @(posedge mclk);
      check("sync reset clear", 16'h0, 16'(sync_generator_reset));
      $display("test sync reset done");
      prev = `RST_OPSEL;
      for (int m = 0; m < 6; m++)
      begin
         lim = 8'($random(seed));
         seg = 8'($random(seed));
         wr(`OFS_OPSEL, modes[m]);
         wr(`OFS_LIMIT, lim);
         wr(`OFS_SEGEN, seg);
         wr(`OFS_PORTCFG, pc[m % 3]);
         check("op before load", 16'(prev), 16'(op_select));
         do_load();
         check("op", 16'(modes[m]), 16'(op_select));
         check("budget", 16'({lim, 1'b0}), 16'(block_bit_budget));
         check("segments", modes[m][7] ? 16'(seg[7:3]) : 16'h0, 16'(segment_enable));
         check("port", 16'(pexp[m % 3]), 16'({code_bus_role, code_transfer_speed,
            code_bus_wide, code_byte_order}));
         prev = modes[m];
      end
      $display("test loads done");
      for (int i = 0; i < 8; i++)
      begin
         d = 8'($random(seed));
         code_fill <= fills[i];
         code_buf_full <= d[0];
         code_buf_empty <= d[1];
         repeat (3) @(posedge mclk);
         rd(`OFS_BUFSTAT, {5'h00, d[0] | d[1], fills[i][5:4]}, 8'h87);
      end
      end_of_image <= 1'b1;
      code_fill <= 7'h00;
      repeat (3) @(posedge mclk);
      rd(`OFS_BUFSTAT, 8'h03, 8'h03);
      end_of_image <= 1'b0;
      $display("test buffer status done");
      wr(`OFS_LIMIT, 8'h3c);
      fork
         i_host_model.nap(12);
         begin
            repeat (6) @(posedge mclk);
            check("asleep", 16'h0, 16'(core_run));
            check("asleep flag", 16'h1, 16'(asleep));
            check("budget asleep", 16'({lim, 1'b0}), 16'(block_bit_budget));
         end
      join
      wait_run();
      check("lock span", 16'h1, 16'(n >= LOCK && n <= LOCK + 6));
      rd(`OFS_LIMIT, 8'h3c, 8'hff);
      do_load();
      check("budget after wake", 16'h78, 16'(block_bit_budget));
      $display("test sleep done");
      repeat (5) @(posedge mclk);
      wrap_up();
   end
endmodule
